// file: verilog/tsac_pkg.sv
// Constants, field layouts and carrier types of the timeslot attribute block.
// Assumes a single 20 MHz clock domain; every user writes tsac_pkg::name.
package tsac_pkg;

    // ****************************************************************
    // Frame geometry and slot addressing
    // ****************************************************************
    localparam int          SLOT_W       = 5;             // Output timeslot field, 0 to 31.
    localparam int          MUX_W        = 3;             // Output multiplex field, 0 to 7.
    localparam int          ADDR_W       = SLOT_W + MUX_W;
    localparam int          DEPTH        = 256;
    localparam logic [2:0]  GCI_MUX_A    = 3'h4;          // First GCI multiplex (fourth pair).
    localparam logic [2:0]  GCI_MUX_B    = 3'h5;          // Second GCI multiplex (fifth pair).
    localparam logic [1:0]  MODE_16K     = 2'h2;          // Mode bits hi=1, lo=0.

    // ****************************************************************
    // Wishbone register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0]  REG_CM_ADDR  = 4'h0;
    localparam logic [3:0]  REG_CM_DATA  = 4'h4;
    localparam logic [3:0]  REG_STATUS   = 4'h8;
    localparam logic [3:0]  REG_CTRL     = 4'hC;
    localparam logic [1:0]  CTRL_RST_VAL = 2'h0;
    localparam int          CTRL_ENABLE  = 0;
    localparam int          CTRL_CLR_ERR = 1;

    // ****************************************************************
    // Scrambler and pseudo-random sequence constants
    // ****************************************************************
    localparam int          SCR_LEN      = 23;            // Taps at 18 and 23 (x^-18 + x^-23).
    localparam int          SCR_TAP_A    = 17;
    localparam int          SCR_TAP_B    = 22;
    localparam int          PRS_LEN      = 15;            // Sequence x^15 + x^14 + 1.
    localparam int          PRS_TAP_A    = 13;
    localparam int          PRS_TAP_B    = 14;
    localparam logic [14:0] PRS_SEED     = 15'h7FFF;
    localparam logic [22:0] SCR_SEED     = 23'h00_0000;
    localparam logic [15:0] ERR_RST_VAL  = 16'h0000;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic       switch_mode_hi;
        logic       switch_mode_lo;
        logic       source_slot_bit3;
        logic       source_slot_bit2;
        logic       source_slot_bit1;
        logic       source_slot_bit0;
        logic       prs_generator_enable;
        logic       analyzer_input_select;
        logic       prs_analyzer_enable;
        logic       sync_pulse_attr;
        logic       scramble_attr;
    } tsac_attr_type;

    localparam int ATTR_W = $bits(tsac_attr_type);

    typedef struct packed {
        logic [MUX_W-1:0]  output_mux_index;
        logic [SLOT_W-1:0] output_slot_index;
    } tsac_dest_type;

endpackage : tsac_pkg

// file: verilog/tsac_attr_mem.sv
// Connection memory attribute store: one write port, one read port.
// Assumes both ports share CLK; read data come out of a register one cycle later.
module tsac_attr_mem
(
    input  wire logic                          CLK,
    input  wire logic                          CE,
    input  wire logic                          WR_EN,
    input  wire logic [tsac_pkg::ADDR_W-1:0]   WR_ADDR,
    input  wire tsac_pkg::tsac_attr_type       WR_DATA,
    input  wire logic [tsac_pkg::ADDR_W-1:0]   RD_ADDR,
    output tsac_pkg::tsac_attr_type            RD_DATA
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    tsac_pkg::tsac_attr_type mem [tsac_pkg::DEPTH];
    tsac_pkg::tsac_attr_type rd_data_ff;

    // Write and registered read; no reset, contents are set by software.
    always_ff @(posedge CLK)
    begin
        if (CE)
        begin
            if (WR_EN)
            begin
                mem[WR_ADDR] <= WR_DATA;
            end
            rd_data_ff <= mem[RD_ADDR];
        end
    end

    assign RD_DATA = rd_data_ff;

endmodule : tsac_attr_mem

// file: verilog/tsac_top.sv
// Timeslot attribute control: per output timeslot attributes of the switching matrix.
// Assumes frame sync and bit clock arrive as pins; matrix data are on the CLK domain.
//
// Overview of operation
// - 16k mode picks four GCI channels, mux four/five.
// - Upstream pack: first channel in bits 7/8.
// - Packed byte goes to destination slot and mux.
// - Downstream takes same-numbered input slot to GCI.
// - Downstream bits 7/8 feed first chosen channel.
// - Analyzer runs only in slots with enable set.
// - Analyzer input: data memory, or generator test.
// - Sync pin follows attribute during its bit time.
// - Slot zero mux zero: first frame bit.
// - Scramble after matrix only where attribute set.
// - Non-GCI multiplexes get the V.29 scrambler.
// - GCI multiplexes get the V.29 descrambler.
// - Attribute zero passes slot data unchanged.
// - Destination: five-bit slot, three-bit multiplex.
module tsac_top
(
    input  wire logic                          CLK,
    input  wire logic                          RST,
    input  wire logic                          CE,
    // Classic Wishbone slave.
    input  wire logic                          WB_CYC_I,
    input  wire logic                          WB_STB_I,
    input  wire logic                          WB_WE_I,
    input  wire logic [3:0]                    WB_ADR_I,
    input  wire logic [3:0]                    WB_SEL_I,
    input  wire logic [31:0]                   WB_DAT_I,
    output logic      [31:0]                   WB_DAT_O,
    output logic                               WB_ACK_O,
    // Frame timing pins.
    input  wire logic                          FRAME_SYNC,
    input  wire logic                          BIT_CLK,
    // Matrix side, same clock domain.
    input  wire logic [7:0]                    SLOT_IN_DATA,
    output tsac_pkg::tsac_dest_type            SLOT_ADDR,
    output logic      [7:0]                    SLOT_OUT_DATA,
    output logic                               SLOT_OUT_VALID,
    // GCI D channels, two bits per channel, eight channels per multiplex.
    input  wire logic [15:0]                   SERIAL_IN_FOUR,
    input  wire logic [15:0]                   SERIAL_IN_FIVE,
    output logic      [15:0]                   SERIAL_OUT_FOUR,
    output logic      [15:0]                   SERIAL_OUT_FIVE,
    // Programmable sync pin and analyzer status.
    output logic                               PROGRAMMABLE_SYNC_PIN,
    output logic                               PRS_ANALYZER_ACTIVE
);

    // ****************************************************************
    // Functions
    // ****************************************************************

    // One byte through the V.29 scrambler (desc=0) or descrambler (desc=1), MSB first.
    function automatic logic [30:0] v29_byte(input logic [22:0] st, input logic [7:0] din, input logic desc);
        logic [22:0] s;
        logic [7:0]  d;
        logic        o;
        s = st;
        d = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            o    = din[i] ^ s[tsac_pkg::SCR_TAP_A] ^ s[tsac_pkg::SCR_TAP_B];
            d[i] = o;
            s    = {s[21:0], desc ? din[i] : o};
        end
        return {s, d};
    endfunction : v29_byte

    // Advance the pseudo-random register by eight bits; returns state and byte.
    function automatic logic [22:0] prs_byte(input logic [14:0] st);
        logic [14:0] s;
        logic [7:0]  d;
        logic        b;
        s = st;
        d = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            b    = s[tsac_pkg::PRS_TAP_A] ^ s[tsac_pkg::PRS_TAP_B];
            d[i] = b;
            s    = {s[13:0], b};
        end
        return {s, d};
    endfunction : prs_byte

    // ****************************************************************
    // Pin synchronisers and bit strobe
    // ****************************************************************
    logic [2:0] bclk_sync_ff, nxt_bclk_sync;
    logic [1:0] fs_sync_ff,   nxt_fs_sync;
    logic       bit_strobe;

    // Three flops for the bit clock, two for frame sync; the edge detector reads only the second and third stages.
    always_comb
    begin
        nxt_bclk_sync = {bclk_sync_ff[1:0], BIT_CLK};
        nxt_fs_sync   = {fs_sync_ff[0], FRAME_SYNC};
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            bclk_sync_ff <= 3'h0;
            fs_sync_ff   <= 2'h0;
        end
        else if (CE)
        begin
            bclk_sync_ff <= nxt_bclk_sync;
            fs_sync_ff   <= nxt_fs_sync;
        end
    end

    assign bit_strobe = bclk_sync_ff[1] & ~bclk_sync_ff[2];

    // ****************************************************************
    // Wishbone register file
    // ****************************************************************
    logic [tsac_pkg::ADDR_W-1:0] cm_addr_ff, nxt_cm_addr;
    tsac_pkg::tsac_attr_type     cm_data_ff, nxt_cm_data;
    logic [1:0]                  ctrl_ff,    nxt_ctrl;
    logic                        ack_ff,     nxt_ack;
    logic [31:0]                 rdat_ff,    nxt_rdat;
    logic                        mem_we;
    logic [15:0]                 err_cnt_ff;
    logic                        bus_req;

    assign bus_req = WB_CYC_I & WB_STB_I & ~ack_ff;

    // One wait state: ack rises the cycle after the request and drops the next.
    // A write to the data register also launches the connection memory write.
    always_comb
    begin
        nxt_cm_addr = cm_addr_ff;
        nxt_cm_data = cm_data_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_ack     = bus_req;
        nxt_rdat    = 32'h0000_0000;
        mem_we      = 1'b0;
        nxt_ctrl[tsac_pkg::CTRL_CLR_ERR] = 1'b0;
        if (bus_req & WB_WE_I & WB_SEL_I[0])
        begin
            unique case (WB_ADR_I)
                tsac_pkg::REG_CM_ADDR: nxt_cm_addr = WB_DAT_I[tsac_pkg::ADDR_W-1:0];
                tsac_pkg::REG_CM_DATA:
                begin
                    nxt_cm_data = tsac_pkg::tsac_attr_type'(WB_DAT_I[tsac_pkg::ATTR_W-1:0]);
                    mem_we      = 1'b1;
                end
                tsac_pkg::REG_CTRL:    nxt_ctrl = WB_DAT_I[1:0];
                default:               nxt_ctrl = nxt_ctrl;
            endcase
        end
        else if (bus_req & ~WB_WE_I)
        begin
            unique case (WB_ADR_I)
                tsac_pkg::REG_CM_ADDR: nxt_rdat = {24'h00_0000, cm_addr_ff};
                tsac_pkg::REG_CM_DATA: nxt_rdat = {21'h00_0000, cm_data_ff};
                tsac_pkg::REG_STATUS:  nxt_rdat = {16'h0000, err_cnt_ff};
                tsac_pkg::REG_CTRL:    nxt_rdat = {30'h0000_0000, ctrl_ff};
                default:               nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cm_addr_ff <= '0;
            cm_data_ff <= '0;
            ctrl_ff    <= tsac_pkg::CTRL_RST_VAL;
            ack_ff     <= 1'b0;
            rdat_ff    <= 32'h0000_0000;
        end
        else if (CE)
        begin
            cm_addr_ff <= nxt_cm_addr;
            cm_data_ff <= nxt_cm_data;
            ctrl_ff    <= nxt_ctrl;
            ack_ff     <= nxt_ack;
            rdat_ff    <= nxt_rdat;
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = rdat_ff;

    // ****************************************************************
    // Frame position and attribute fetch
    // ****************************************************************
    logic [4:0]              slot_ff, nxt_slot;
    logic [2:0]              bitn_ff, nxt_bitn;
    logic [1:0]              fetch_ff, nxt_fetch;
    tsac_pkg::tsac_dest_type dest_ff, nxt_dest;
    tsac_pkg::tsac_attr_type attr;

    // Bit q of slot y addresses the entry of output slot y on multiplex q, so every entry
    // is fetched once a frame and software writes show at the entry's next fetch, within one frame.
    always_comb
    begin
        nxt_slot  = slot_ff;
        nxt_bitn  = bitn_ff;
        nxt_fetch = {fetch_ff[0], 1'b0};  // Second stage waits for the registered memory read.
        nxt_dest  = dest_ff;
        if (bit_strobe)
        begin
            if (fs_sync_ff[1])
            begin
                nxt_slot = 5'h00;
                nxt_bitn = 3'h0;
            end
            else
            begin
                nxt_bitn = bitn_ff + 3'h1;
                nxt_slot = (bitn_ff == 3'h7) ? slot_ff + 5'h01 : slot_ff;
            end
            nxt_fetch[0] = ctrl_ff[tsac_pkg::CTRL_ENABLE];
            nxt_dest  = '{output_mux_index: nxt_bitn, output_slot_index: nxt_slot};
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            slot_ff  <= 5'h00;
            bitn_ff  <= 3'h0;
            fetch_ff <= 2'h0;
            dest_ff  <= '0;
        end
        else if (CE)
        begin
            slot_ff  <= nxt_slot;
            bitn_ff  <= nxt_bitn;
            fetch_ff <= nxt_fetch;
            dest_ff  <= nxt_dest;
        end
    end

    tsac_attr_mem u_attr_mem
    (
        .CLK     (CLK),
        .CE      (CE),
        .WR_EN   (mem_we),
        .WR_ADDR (cm_addr_ff),
        .WR_DATA (nxt_cm_data),
        .RD_ADDR (dest_ff),
        .RD_DATA (attr)
    );

    assign SLOT_ADDR = dest_ff;

    // ****************************************************************
    // Slot processing: D-channel mapping, scrambling, analyzer, sync pin
    // ****************************************************************
    logic [7:0]  out_data_ff, nxt_out_data;
    logic        out_valid_ff, nxt_out_valid;
    logic [15:0] serial_out_four_ff, nxt_serial_out_four, serial_out_five_ff, nxt_serial_out_five;
    logic        sync_ff, nxt_sync, active_ff, nxt_active;
    logic [22:0] scr_ff, nxt_scr;
    logic [14:0] gen_ff, nxt_gen, ana_ff, nxt_ana;
    logic [15:0] nxt_err;
    logic        is_16k, is_gci, hi_half;
    logic [15:0] din_sel;
    logic [7:0]  packed_d, ana_in;
    logic [22:0] gen_step, ana_step;
    logic [30:0] scr_res;

    // The D channels occupy two bits each; channel n sits at bits 2n+1:2n of the bus.
    always_comb
    begin
        is_16k   = ({attr.switch_mode_hi, attr.switch_mode_lo} == tsac_pkg::MODE_16K)
                   & attr.source_slot_bit3;
        is_gci   = (dest_ff.output_mux_index == tsac_pkg::GCI_MUX_A) |
                   (dest_ff.output_mux_index == tsac_pkg::GCI_MUX_B);
        hi_half  = attr.source_slot_bit0;
        din_sel  = attr.source_slot_bit1 ? SERIAL_IN_FIVE : SERIAL_IN_FOUR;
        packed_d = hi_half ? {din_sel[9:8], din_sel[11:10], din_sel[13:12], din_sel[15:14]}
                           : {din_sel[1:0], din_sel[3:2],   din_sel[5:4],   din_sel[7:6]};
        gen_step = prs_byte(gen_ff);
        ana_in   = attr.analyzer_input_select ? gen_step[7:0] : SLOT_IN_DATA;
        ana_step = prs_byte(ana_ff);
        scr_res  = v29_byte(scr_ff, is_16k ? packed_d : SLOT_IN_DATA, is_gci);
        nxt_out_data  = out_data_ff;
        nxt_out_valid = 1'b0;
        nxt_serial_out_four     = serial_out_four_ff;
        nxt_serial_out_five     = serial_out_five_ff;
        nxt_sync      = sync_ff;
        nxt_active    = active_ff;
        nxt_scr       = scr_ff;
        nxt_gen       = gen_ff;
        nxt_ana       = ana_ff;
        nxt_err       = err_cnt_ff;
        if (fetch_ff[1])
        begin
            nxt_sync      = attr.sync_pulse_attr;
            nxt_out_valid = 1'b1;
            if (attr.scramble_attr)
            begin
                nxt_out_data = scr_res[7:0];
                nxt_scr      = scr_res[30:8];
            end
            else
            begin
                nxt_out_data = is_16k ? packed_d : SLOT_IN_DATA;
            end
            if (is_16k)
            begin
                // Same-numbered input slot, bits 7/8 to the first chosen channel.
                if (attr.source_slot_bit1)
                begin
                    if (hi_half) nxt_serial_out_five[15:8] = {SLOT_IN_DATA[1:0], SLOT_IN_DATA[3:2],
                                                    SLOT_IN_DATA[5:4], SLOT_IN_DATA[7:6]};
                    else         nxt_serial_out_five[7:0]  = {SLOT_IN_DATA[1:0], SLOT_IN_DATA[3:2],
                                                    SLOT_IN_DATA[5:4], SLOT_IN_DATA[7:6]};
                end
                else
                begin
                    if (hi_half) nxt_serial_out_four[15:8] = {SLOT_IN_DATA[1:0], SLOT_IN_DATA[3:2],
                                                    SLOT_IN_DATA[5:4], SLOT_IN_DATA[7:6]};
                    else         nxt_serial_out_four[7:0]  = {SLOT_IN_DATA[1:0], SLOT_IN_DATA[3:2],
                                                    SLOT_IN_DATA[5:4], SLOT_IN_DATA[7:6]};
                end
            end
            if (attr.prs_generator_enable)
            begin
                nxt_gen = gen_step[22:8];
            end
            // Input select high without the generator leaves the analyzer with no source.
            nxt_active = attr.prs_analyzer_enable &
                         (~attr.analyzer_input_select | attr.prs_generator_enable);
            if (nxt_active)
            begin
                nxt_ana = ana_step[22:8];
                if ((ana_in != ana_step[7:0]) && (err_cnt_ff != 16'hFFFF))
                begin
                    nxt_err = err_cnt_ff + 16'h0001;
                end
            end
        end
        if (ctrl_ff[tsac_pkg::CTRL_CLR_ERR])
        begin
            nxt_err = tsac_pkg::ERR_RST_VAL;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            out_data_ff  <= 8'h00;
            out_valid_ff <= 1'b0;
            serial_out_four_ff     <= 16'h0000;
            serial_out_five_ff     <= 16'h0000;
            sync_ff      <= 1'b0;
            active_ff    <= 1'b0;
            scr_ff       <= tsac_pkg::SCR_SEED;
            gen_ff       <= tsac_pkg::PRS_SEED;
            ana_ff       <= tsac_pkg::PRS_SEED;
            err_cnt_ff   <= tsac_pkg::ERR_RST_VAL;
        end
        else if (CE)
        begin
            out_data_ff  <= nxt_out_data;
            out_valid_ff <= nxt_out_valid;
            serial_out_four_ff     <= nxt_serial_out_four;
            serial_out_five_ff     <= nxt_serial_out_five;
            sync_ff      <= nxt_sync;
            active_ff    <= nxt_active;
            scr_ff       <= nxt_scr;
            gen_ff       <= nxt_gen;
            ana_ff       <= nxt_ana;
            err_cnt_ff   <= nxt_err;
        end
    end

    assign SLOT_OUT_DATA         = out_data_ff;
    assign SLOT_OUT_VALID        = out_valid_ff;
    assign SERIAL_OUT_FOUR       = serial_out_four_ff;
    assign SERIAL_OUT_FIVE       = serial_out_five_ff;
    assign PROGRAMMABLE_SYNC_PIN = sync_ff;
    assign PRS_ANALYZER_ACTIVE   = active_ff;

endmodule : tsac_top

// file: verification/tsac_checker.sv
// Port assertions for the timeslot attribute block.
// Assumes one CLK domain with synchronous active-high RST.
module tsac_checker
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        SLOT_OUT_VALID,
    input wire logic        PROGRAMMABLE_SYNC_PIN,
    input wire logic        PRS_ANALYZER_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Held outputs may move on the edge leaving reset, so that edge is excused.
    a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
    a_ack_idle: assert property (!WB_CYC_I && !$past(WB_CYC_I) |-> !WB_ACK_O) else $error("stray ack");
    a_gap_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[1:0] != 0 |-> WB_DAT_O == 0) else $error("gap");
    a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 0) else $error("upper bits");
    a_valid_pulse: assert property (SLOT_OUT_VALID |=> !SLOT_OUT_VALID) else $error("valid long");
    a_sync_hold: assert property (!SLOT_OUT_VALID && !$past(RST) |-> $stable(PROGRAMMABLE_SYNC_PIN)) else $error("sync");
    a_prs_hold: assert property (!SLOT_OUT_VALID && !$past(RST) |-> $stable(PRS_ANALYZER_ACTIVE)) else $error("prs");
    c_write: cover property (WB_ACK_O && WB_WE_I);
    c_sync: cover property (SLOT_OUT_VALID && PROGRAMMABLE_SYNC_PIN);
    c_prs: cover property (SLOT_OUT_VALID && PRS_ANALYZER_ACTIVE);
endmodule : tsac_checker

bind tsac_top tsac_checker i_tsac_checker (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O,
    .WB_ACK_O, .SLOT_OUT_VALID, .PROGRAMMABLE_SYNC_PIN, .PRS_ANALYZER_ACTIVE);

// file: verification/tsac_far.sv
// Far side: bit clock, frame sync and the matrix byte of the addressed slot.
// Assumes the design's CLK; ten clocks per bit, 256 bits per frame.
module tsac_far
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] slot_addr,
    output logic            bit_clk,
    output logic            frame_sync,
    output logic [7:0]      slot_data,
    output logic [7:0]      bit_pos
);
    timeunit 1ns;
    timeprecision 1ns;
    int tick = 0;
    // The byte follows the address a cycle late, so a stale value shows first.
    always @(posedge clk)
    begin
        tick       <= rst ? 0 : (tick + 1) % 2560;
        bit_clk    <= tick % 10 < 5;
        frame_sync <= tick < 10;
        bit_pos    <= 8'(tick / 10);
        slot_data  <= slot_addr * 8'h1D ^ 8'hA5;
    end
endmodule : tsac_far

// file: verification/tsac_top_bench.sv
// Self-checking bench with a reference model of each processed slot.
// Assumes the package, the design, the checker and tsac_far come first.
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("BAD %s %h %h", n, e, g); end end
module tsac_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK = 0, RST = 1, cyc = 0, stb = 0, we = 0, ack, fs, bc, sv, ps, pa, chk = 0;
    logic [3:0]  adr = 0, sel = 0;
    logic [7:0]  si, so, pos, din, sa, x, y;
    logic [22:0] h = 0;
    logic [15:0] i4 = 0, i5 = 0, o4, o5, gi, go;
    logic [31:0] wd = 0, rdat, rd;
    int          attr[256], a, err_total = 0, compares = 0, cycles = 0, seed = 32'h2586, sn = 0;

    tsac_top i_tsac_top (.CLK, .RST, .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack), .FRAME_SYNC(fs),
        .BIT_CLK(bc), .SLOT_IN_DATA(si), .SLOT_ADDR(sa), .SLOT_OUT_DATA(so), .SLOT_OUT_VALID(sv),
        .SERIAL_IN_FOUR(i4), .SERIAL_IN_FIVE(i5), .SERIAL_OUT_FOUR(o4), .SERIAL_OUT_FIVE(o5),
        .PROGRAMMABLE_SYNC_PIN(ps), .PRS_ANALYZER_ACTIVE(pa));
    tsac_far i_tsac_far (.clk(CLK), .rst(RST), .slot_addr(sa), .bit_clk(bc), .frame_sync(fs),
        .slot_data(si), .bit_pos(pos));

    // Free-running 20 MHz clock.
    initial
    begin
        forever #25 CLK = ~CLK;
    end

    // Reference of each processed entry at its result pulse; a hang ends the run.
    always @(posedge CLK)
    begin
        cycles++;
        a = attr[sa];
        din = sa * 8'h1D ^ 8'hA5;
        gi = (a[6] ? i5 : i4) >> (a[5] * 8);
        go = (a[6] ? o5 : o4) >> (a[5] * 8);
        if (!chk)
            sn = 0;
        if (chk && sv)
        begin
            x = a[8] ? {gi[1:0], gi[3:2], gi[5:4], gi[7:6]} : din;
            `CHK("addr", {pos[2:0], pos[7:3]}, sa)
            `CHK("sync", a[1], ps)
            `CHK("prs", a[2] & (!a[3] | a[4]), pa)
            if (a[0])
            begin
                // Self-synchronising model: three seen bytes refill the shared state, so only later ones count.
                for (int i = 7; i >= 0; i--)
                begin
                    y[i] = x[i] ^ h[tsac_pkg::SCR_TAP_A] ^ h[tsac_pkg::SCR_TAP_B];
                    h    = {h[21:0], (sa[7:5] == tsac_pkg::GCI_MUX_A || sa[7:5] == tsac_pkg::GCI_MUX_B) ? x[i] : so[i]};
                end
                sn++;
                if (sn > 3)
                    `CHK("scr", y, so)
            end
            else
                `CHK("out", x, so)
            if (a[8])
                `CHK("down", {din[1:0], din[3:2], din[5:4], din[7:6]}, go[7:0])
        end
        if (cycles == 40000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // One classic cycle: the request stands until ack is seen at a rising edge.
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d, input logic [3:0] s);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        adr <= ad;
        wd  <= d;
        sel <= s;
        do
            @(posedge CLK);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge CLK);
    endtask : wb

    task end_of_test;
        $display("err_total %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    // Two random loads, each checked over three frames from the next frame start.
    initial
    begin
        repeat (4) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        wb(0, 4'h2, 32'h0, 4'hF);
        `CHK("gap", 32'h0, rd)
        for (int ph = 0; ph < 2; ph++)
        begin
            chk <= 0;
            @(posedge CLK);
            i4 <= $random(seed);
            i5 <= $random(seed);
            for (int e = 0; e < 256; e++)
            begin
                attr[e] = $random(seed) & 11'h0FE; // Scrambling off unless chosen below.
                if (e % 3 == 0)
                    attr[e] = attr[e] | 11'h500;
                if (ph == 1 && e[4] == 1'b0 && (e[7:5] == 1 || (e[7:5] == 4 && e[1] == 1'b0)))
                    attr[e] = attr[e] | 1; // Sixteen TDM slots, eight GCI A slots.
                wb(1, 4'h0, e, 4'hF);
                wb(1, 4'h4, attr[e], 4'hF);
            end
            wb(0, 4'h4, 32'h0, 4'hF);
            `CHK("entry", attr[255], rd)
            wb(1, 4'hC, 32'h3, 4'hF);
            wb(1, 4'hC, 32'h0, 4'hE);
            wb(0, 4'hC, 32'h0, 4'hF);
            `CHK("ctrl", 32'h1, rd)
            @(posedge fs);
            @(posedge CLK);
            chk <= 1;
            repeat (7680) @(posedge CLK);
        end
        end_of_test();
    end
endmodule : tsac_top_bench
